//--- design/dsp_core_control_pins.sv
// Chip level control pin logic around the fixed point core.
// Assumes core side strobes are synchronous to clk_i; pins are pre-sampled.
`timescale 1ns/1ps
`default_nettype none

module dsp_core_control_pins
  import ctl_pkg::*;
#(
  parameter int unsigned AW = ctl_pkg::ADDR_W
)
(
  input  wire logic          clk_i,                // Core clock, 40 MHz.
  input  wire logic          reset_n_i,            // Chip reset, low.
  input  wire logic          trst_n_i,             // Test logic reset, low.
  input  wire logic          xfer_ack_n_i,         // External acknowledge, low.
  input  wire logic          bus_switch_ack_n_i,   // Bus switch acknowledge, low.
  input  wire logic          ext_access_i,         // Core external access active.
  output logic               core_xfer_ack_n_o,    // Acknowledge to core, low.
  output logic               core_wait_o,          // Wait state to core.
  input  wire logic          bus_hold_req_n_i,     // Bus hold request, low.
  output logic               bus_hold_ack_n_o,     // Hold acknowledge, low.
  output logic               core_hold_o,          // Stalls new core accesses.
  input  wire logic [AW-1:0] core_iaddr_i,         // Core instruction address.
  input  wire logic          core_istrobe_i,       // Core instruction access.
  input  wire logic          core_iwrite_i,        // Core instruction write.
  output logic [AW-1:0]      instr_ext_addr_o,     // Extension address.
  output logic               instr_ext_strobe_n_o, // Extension strobe, low.
  output logic               instr_ext_oe_o,       // Drives address and strobe.
  output logic               prog_rw_ind_o,        // High on write access.
  output logic               core_reset_n_o,       // Core reset, low.
  output logic               sys_reset_out_n_o,    // System reset out, low.
  input  wire logic          reset_mode_i,         // Reset vector select.
  output logic [15:0]        reset_vector_o,       // Start address.
  input  wire logic          low_power_req_n_i,    // Low power request, low.
  input  wire logic          core_lp_idle_i,       // Core ready to sleep.
  output logic               core_low_power_o,     // Low power to core.
  output logic               low_power_ack_n_o,    // Low power ack, low.
  input  wire logic          instr_cycle_i,        // Instruction cycle start.
  input  wire logic          copro_next_i,         // Next is coprocessor op.
  input  wire logic          xstack_op_i,          // Current is X stack op.
  input  wire logic          ystack_op_i,          // Current is Y stack op.
  output logic               copro_valid_n_o,      // Coprocessor valid, low.
  output logic               xstack_flag_o,        // X stack flag.
  output logic               ystack_flag_o,        // Y stack flag.
  input  wire logic          ibus_direct_en_n_i,   // Direct transfer enable pin.
  output logic               bus_switch_direct_en_n_o, // Same, to bus switch.
  output logic               ibus_direct_o,        // Route directly when high.
  input  wire logic          emu_halt_req_n_i,     // Emulator halt, low.
  input  wire logic          xaddr_bp_en_i,        // X breakpoint enable.
  input  wire logic          yaddr_bp_en_i,        // Y breakpoint enable.
  input  wire logic          iaddr_bp_en_i,        // I breakpoint enable.
  input  wire logic          x_bp_match_i,         // X address match.
  input  wire logic          y_bp_match_i,         // Y address match.
  input  wire logic          i_bp_match_i,         // I address match.
  input  wire logic          emu_step_i,           // Single step pulse.
  input  wire logic          emu_resume_i,         // Resume pulse.
  input  wire logic          snapshot_out_mode_i,          // Snapshot mode enable.
  output logic               core_halt_o,          // Halt to core.
  output logic               idle_flag_o,          // Idle flag.
  output logic               halt_ack_a_o,         // Halt acknowledge, high.
  output logic               snapshot_out_o        // Snapshot, high.
);

  // ----------------------------------------------------------------
  // Reset synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_STAGES-1:0] rst_sync_q;
  logic [SYNC_STAGES-1:0] emu_sync_q;
  logic                   rst_n;
  logic                   emu_rst_n;
  logic                   emu_rst_async_n;

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rst_sync_q <= '0;
    else
      rst_sync_q <= {rst_sync_q[SYNC_STAGES-2:0], 1'b1};
  end

  // Either reset clears the emulation unit; release is synchronous.
  assign emu_rst_async_n = reset_n_i & trst_n_i;

  always_ff @(posedge clk_i or negedge emu_rst_async_n)
  begin
    if (!emu_rst_async_n)
      emu_sync_q <= '0;
    else
      emu_sync_q <= {emu_sync_q[SYNC_STAGES-2:0], 1'b1};
  end

  assign rst_n     = rst_sync_q[SYNC_STAGES-1];
  assign emu_rst_n = emu_sync_q[SYNC_STAGES-1];

  // ----------------------------------------------------------------
  // Reset outputs and reset vector
  // ----------------------------------------------------------------
  logic        core_rst_q;
  logic        sys_rst_q;
  logic        boot_pending_q;
  logic        mode_q;
  logic [15:0] vec_q;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_rst_q     <= 1'b0;
      sys_rst_q      <= 1'b0;
      boot_pending_q <= 1'b1;
      mode_q         <= 1'b0;
      vec_q          <= VEC_LOW;
    end
    else
    begin
      core_rst_q     <= 1'b1;
      sys_rst_q      <= 1'b1;
      boot_pending_q <= 1'b0;
      if (boot_pending_q)
      begin
        mode_q <= reset_mode_i;
        vec_q  <= reset_mode_i ? VEC_HIGH : VEC_LOW;
      end
    end
  end

  assign core_reset_n_o    = core_rst_q;
  assign sys_reset_out_n_o = sys_rst_q;
  assign reset_vector_o    = vec_q;

  // ----------------------------------------------------------------
  // Transfer acknowledge and wait states
  // ----------------------------------------------------------------
  logic ack_n;

  assign ack_n             = xfer_ack_n_i | bus_switch_ack_n_i;
  assign core_xfer_ack_n_o = ack_n;
  assign core_wait_o       = ext_access_i & ack_n;

  // ----------------------------------------------------------------
  // Bus hold handshake
  // ----------------------------------------------------------------
  hold_state_t hold_q;
  hold_state_t hold_d;
  logic        hold_req;

  assign hold_req = !bus_hold_req_n_i;

  always_comb
  begin
    hold_d = hold_q;
    unique case (hold_q)
      H_IDLE:
        if (hold_req)
          hold_d = H_DRAIN;
      H_DRAIN:
        if (!hold_req)
          hold_d = H_IDLE;
        else if (!ext_access_i)
          hold_d = H_GRANT;
      H_GRANT:
        if (!hold_req)
          hold_d = H_IDLE;
      default:
        hold_d = H_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      hold_q <= H_IDLE;
    else
      hold_q <= hold_d;
  end

  assign bus_hold_ack_n_o = (hold_q != H_GRANT);
  assign core_hold_o      = (hold_q != H_IDLE);
  assign instr_ext_oe_o   = (hold_q != H_GRANT);

  // ----------------------------------------------------------------
  // Instruction extension bus
  // ----------------------------------------------------------------
  logic [AW-1:0] iaddr_q;
  logic          istb_n_q;
  logic          rw_q;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      iaddr_q  <= ADDR_RST[AW-1:0];
      istb_n_q <= 1'b1;
      rw_q     <= 1'b0;
    end
    else
    begin
      iaddr_q  <= core_iaddr_i;
      istb_n_q <= !(core_istrobe_i && hold_q == H_IDLE);
      if (core_istrobe_i)
        rw_q <= core_iwrite_i;
    end
  end

  assign instr_ext_addr_o     = iaddr_q;
  assign instr_ext_strobe_n_o = istb_n_q;
  assign prog_rw_ind_o        = rw_q;

  // ----------------------------------------------------------------
  // Instruction bus routing
  // ----------------------------------------------------------------
  assign bus_switch_direct_en_n_o = ibus_direct_en_n_i;
  assign ibus_direct_o            = mode_q & ibus_direct_en_n_i;

  // ----------------------------------------------------------------
  // Low power handshake
  // ----------------------------------------------------------------
  logic lp_req_q;
  logic lp_ack_q;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lp_req_q <= 1'b0;
      lp_ack_q <= 1'b0;
    end
    else
    begin
      lp_req_q <= !low_power_req_n_i;
      lp_ack_q <= !low_power_req_n_i && (lp_ack_q || core_lp_idle_i);
    end
  end

  assign core_low_power_o  = lp_req_q;
  assign low_power_ack_n_o = !lp_ack_q;

  // ----------------------------------------------------------------
  // Coprocessor and stack flags, held for one instruction cycle
  // ----------------------------------------------------------------
  logic copro_q;
  logic xstk_q;
  logic ystk_q;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      copro_q <= 1'b0;
      xstk_q  <= 1'b0;
      ystk_q  <= 1'b0;
    end
    else if (instr_cycle_i)
    begin
      copro_q <= copro_next_i;
      xstk_q  <= xstack_op_i;
      ystk_q  <= ystack_op_i;
    end
  end

  assign copro_valid_n_o = !copro_q;
  assign xstack_flag_o   = xstk_q;
  assign ystack_flag_o   = ystk_q;

  // ----------------------------------------------------------------
  // Emulation unit
  // ----------------------------------------------------------------
  emu_if eb ();
  logic  bp_hit;

  assign bp_hit = (xaddr_bp_en_i & x_bp_match_i)
                | (yaddr_bp_en_i & y_bp_match_i)
                | (iaddr_bp_en_i & i_bp_match_i);

  assign eb.halt_req    = !emu_halt_req_n_i;
  assign eb.bp_hit      = bp_hit;
  assign eb.step        = emu_step_i;
  assign eb.resume      = emu_resume_i;
  assign eb.instr_cycle = instr_cycle_i;
  assign eb.snapshot_out_mode   = snapshot_out_mode_i;

  emu_status u_emu (
    .clk_i   (clk_i),
    .rst_n_i (emu_rst_n),
    .eu      (eb.emu)
  );

  assign core_halt_o    = eb.halt;
  assign idle_flag_o    = eb.idle;
  assign halt_ack_a_o   = eb.halt_ack;
  assign snapshot_out_o = eb.snapshot_out;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence hold_asked_idle_bus;
    hold_req && !ext_access_i && (hold_q == H_DRAIN);
  endsequence

  AST_ACK_BOTH_LOW: assert property (!core_xfer_ack_n_o |->
                                     !xfer_ack_n_i && !bus_switch_ack_n_i)
    else $error("core acknowledge without both acknowledges low");
  AST_WAIT_STRETCH: assert property (ext_access_i && xfer_ack_n_i |-> core_wait_o)
    else $error("no wait state while external acknowledge high");
  AST_HOLD_GRANT: assert property (hold_asked_idle_bus |=> !bus_hold_ack_n_o)
    else $error("hold not granted after bus went idle");
  AST_HOLD_CAUSE: assert property ($fell(bus_hold_ack_n_o) |-> $past(hold_req, 2))
    else $error("hold acknowledge without request");
  AST_BUS_RELEASE: assert property (!bus_hold_ack_n_o |->
                                    !instr_ext_oe_o && instr_ext_strobe_n_o)
    else $error("extension bus driven during hold");
  AST_VECTOR: assert property (boot_pending_q |=>
                               reset_vector_o == ($past(reset_mode_i) ? VEC_HIGH : VEC_LOW))
    else $error("reset vector does not follow reset mode");
  AST_LP_ACK: assert property (!low_power_ack_n_o |-> !$past(low_power_req_n_i))
    else $error("low power acknowledge without request");
  AST_COPRO: assert property (instr_cycle_i && copro_next_i |=> !copro_valid_n_o)
    else $error("coprocessor valid not asserted");
  AST_ROUTE: assert property (ibus_direct_o |->
                              ibus_direct_en_n_i && (reset_vector_o == VEC_HIGH))
    else $error("direct route without high mode and enable");

endmodule

`default_nettype wire

//--- design/emu_status.sv
// Emulation halt, single step, idle and snapshot status.
// Assumes a reset that already combines system and test logic reset.
`timescale 1ns/1ps
`default_nettype none

module emu_status
  import ctl_pkg::*;
(
  input  wire logic clk_i,   // Core clock.
  input  wire logic rst_n_i, // Synchronised emulation reset.
  emu_if.emu        eu       // Requests in, status out.
);

  emu_state_t state_q;
  emu_state_t state_d;
  logic       idle_q;
  logic       ack_q;
  logic       snapshot_out_q;

  // ----------------------------------------------------------------
  // Halt state machine
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      E_RUN:
        if (eu.halt_req || eu.bp_hit)
          state_d = E_HALT;
      E_HALT:
        if (eu.step)
          state_d = E_STEP;
        else if (eu.resume && !eu.halt_req)
          state_d = E_RUN;
      E_STEP:
        state_d = E_HALT;
      default:
        state_d = E_HALT;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= E_RUN;
      idle_q  <= 1'b0;
      ack_q   <= 1'b0;
      snapshot_out_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      idle_q  <= (state_d == E_HALT);
      ack_q   <= (state_d != E_RUN);
      snapshot_out_q  <= eu.snapshot_out_mode && eu.instr_cycle && (state_d != E_HALT);
    end
  end

  assign eu.halt     = (state_q == E_HALT);
  assign eu.idle     = idle_q;
  assign eu.halt_ack = ack_q;
  assign eu.snapshot_out     = snapshot_out_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence run_and_asked;
    (state_q == E_RUN) && (eu.halt_req || eu.bp_hit);
  endsequence

  AST_HALT_ENTRY: assert property (run_and_asked |=> eu.halt && eu.halt_ack)
    else $error("halt request did not halt the core");
  AST_IDLE_STEP: assert property ((state_q == E_STEP) |-> !eu.idle ##1 eu.idle)
    else $error("idle flag wrong around a single step");
  AST_ACK_HELD: assert property (eu.halt |-> eu.halt_ack)
    else $error("halt acknowledge missing while halted");
  AST_SNAPSHOT_OUT_ONLY_EN: assert property (eu.snapshot_out |-> $past(eu.snapshot_out_mode))
    else $error("snapshot pulse without snapshot mode");

endmodule

`default_nettype wire

//--- include/ctl_pkg.sv
// Shared constants and types for the core control pin logic.
// Assumes a single 40 MHz clock domain and 16-bit instruction addresses.
package ctl_pkg;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 16;
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic [15:0] VEC_LOW     = 16'h0000;
  localparam logic [15:0] VEC_HIGH    = 16'hfc00;
  localparam logic [15:0] ADDR_RST    = 16'h0000;

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    H_IDLE  = 3'b001,
    H_DRAIN = 3'b010,
    H_GRANT = 3'b100
  } hold_state_t;

  typedef enum logic [2:0] {
    E_RUN  = 3'b001,
    E_HALT = 3'b010,
    E_STEP = 3'b100
  } emu_state_t;

endpackage

//--- include/emu_if.sv
// Carrier between the control pin logic and its emulation status unit.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none

interface emu_if;
  logic halt_req;
  logic bp_hit;
  logic step;
  logic resume;
  logic instr_cycle;
  logic snapshot_out_mode;
  logic halt;
  logic idle;
  logic halt_ack;
  logic snapshot_out;

  modport ctl (
    output halt_req, bp_hit, step, resume, instr_cycle, snapshot_out_mode,
    input  halt, idle, halt_ack, snapshot_out
  );
  modport emu (
    input  halt_req, bp_hit, step, resume, instr_cycle, snapshot_out_mode,
    output halt, idle, halt_ack, snapshot_out
  );
endinterface

`default_nettype wire

//--- testbench/ext_party.sv
// Model of the far side: external memory acknowledge and a bus master.
// Assumes one clock shared with the control pin logic.
`timescale 1ns/1ps
`default_nettype none

module ext_party (
  input  wire logic       clk_i,           // Core clock.
  input  wire logic       ext_access_i,    // Access pending.
  input  wire logic [2:0] waits_i,         // Wait states wanted.
  input  wire logic       hold_want_i,     // Buses wanted.
  output logic            xfer_ack_n_o,    // Acknowledge, low.
  output logic            bus_hold_req_n_o // Hold request, low.
);
  logic [2:0] cnt_q;
  logic       done;

  assign done = (cnt_q == waits_i);
  always_ff @(posedge clk_i)
    cnt_q <= ext_access_i ? (done ? cnt_q : cnt_q + 3'h1) : 3'h0;
  // Acknowledge is held inactive to stretch the cycle.
  assign xfer_ack_n_o     = !(ext_access_i && done);
  assign bus_hold_req_n_o = !hold_want_i;
endmodule

`default_nettype wire

//--- testbench/tb_dsp_core_control_pins.sv
// Self-checking bench for the control pin logic.
// Assumes the far side model ext_party and the package ctl_pkg.
`timescale 1ns/1ps
`default_nettype none

module tb_dsp_core_control_pins;
  import ctl_pkg::*;
  logic clk_i = 1'h0, reset_n_i = 1'h0, trst_n_i = 1'h0, hold_want = 1'h0;
  logic bus_switch_ack_n_i = 1'h1, ext_access_i = 1'h0, core_istrobe_i = 1'h0;
  logic core_iwrite_i = 1'h0, reset_mode_i = 1'h0, low_power_req_n_i = 1'h1;
  logic core_lp_idle_i = 1'h0, instr_cycle_i = 1'h0, copro_next_i = 1'h0;
  logic xstack_op_i = 1'h0, ystack_op_i = 1'h0, ibus_direct_en_n_i = 1'h0;
  logic emu_halt_req_n_i = 1'h1, xaddr_bp_en_i = 1'h0, yaddr_bp_en_i = 1'h0;
  logic iaddr_bp_en_i = 1'h0, x_bp_match_i = 1'h0, y_bp_match_i = 1'h0;
  logic i_bp_match_i = 1'h0, emu_step_i = 1'h0, emu_resume_i = 1'h0, snapshot_out_mode_i = 1'h0;
  logic [2:0]  waits = 3'h0;
  logic [15:0] core_iaddr_i = 16'h0;
  wire logic xfer_ack_n_i, bus_hold_req_n_i, core_xfer_ack_n_o, core_wait_o;
  wire logic bus_hold_ack_n_o, core_hold_o, instr_ext_strobe_n_o, instr_ext_oe_o;
  wire logic prog_rw_ind_o, core_reset_n_o, sys_reset_out_n_o, core_low_power_o;
  wire logic low_power_ack_n_o, copro_valid_n_o, xstack_flag_o, ystack_flag_o;
  wire logic bus_switch_direct_en_n_o, ibus_direct_o, core_halt_o, idle_flag_o;
  wire logic halt_ack_a_o, snapshot_out_o;
  wire logic [15:0] instr_ext_addr_o, reset_vector_o;
  int err_total = 0, cmp_count = 0, cyc = 0, seed = 10;

  dsp_core_control_pins dut_u (.clk_i, .reset_n_i, .trst_n_i, .xfer_ack_n_i,
    .bus_switch_ack_n_i, .ext_access_i, .core_xfer_ack_n_o, .core_wait_o,
    .bus_hold_req_n_i, .bus_hold_ack_n_o, .core_hold_o, .core_iaddr_i, .core_istrobe_i,
    .core_iwrite_i, .instr_ext_addr_o, .instr_ext_strobe_n_o, .instr_ext_oe_o,
    .prog_rw_ind_o, .core_reset_n_o, .sys_reset_out_n_o, .reset_mode_i, .reset_vector_o,
    .low_power_req_n_i, .core_lp_idle_i, .core_low_power_o, .low_power_ack_n_o,
    .instr_cycle_i, .copro_next_i, .xstack_op_i, .ystack_op_i, .copro_valid_n_o,
    .xstack_flag_o, .ystack_flag_o, .ibus_direct_en_n_i, .bus_switch_direct_en_n_o,
    .ibus_direct_o, .emu_halt_req_n_i, .xaddr_bp_en_i, .yaddr_bp_en_i, .iaddr_bp_en_i,
    .x_bp_match_i, .y_bp_match_i, .i_bp_match_i, .emu_step_i, .emu_resume_i,
    .snapshot_out_mode_i, .core_halt_o, .idle_flag_o, .halt_ack_a_o, .snapshot_out_o);
  ext_party pm_u (.clk_i, .ext_access_i, .waits_i(waits), .hold_want_i(hold_want),
    .xfer_ack_n_o(xfer_ack_n_i), .bus_hold_req_n_o(bus_hold_req_n_i));

  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      test_done();
    end
  end

  function automatic logic [15:0] exp_vec(input logic m);
    return m ? 16'hfc00 : 16'h0000;
  endfunction

  task automatic chk(input logic got, input logic exp, input string m);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask

  task automatic test_done();
    $display("Compares %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic tk(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Resets the chip with the given mode, then checks the start address.
  task automatic do_reset(input logic m, input int n);
    reset_n_i = 1'h0;
    reset_mode_i = m;
    tk(n);
    chk(core_reset_n_o, 1'h0, "core reset");
    chk(sys_reset_out_n_o, 1'h0, "sys reset");
    reset_n_i = 1'h1;
    trst_n_i = 1'h1;
    tk(5);
    chk(core_reset_n_o, 1'h1, "core run");
    chk(sys_reset_out_n_o, 1'h1, "sys run");
    chk(reset_vector_o === exp_vec(m), 1'h1, "vector");
    for (int p = 0; p < 2; p++)
    begin
      ibus_direct_en_n_i = p[0];
      #1 chk(ibus_direct_o, m & p[0], "route");
      chk(bus_switch_direct_en_n_o, p[0], "to switch");
    end
  endtask

  initial
  begin
    logic [15:0] a;
    logic s, w, rw, ic, ec, ex, ey, es;
    do_reset(1'h0, 12);
    // Random acknowledge traffic, then a counted wait sequence.
    for (int i = 0; i < 40; i++)
    begin
      tk(1);
      bus_switch_ack_n_i = 1'($random(seed));
      ext_access_i = 1'($random(seed));
      waits = 3'($random(seed));
      #1 chk(core_xfer_ack_n_o, xfer_ack_n_i | bus_switch_ack_n_i, "ack or");
      chk(core_wait_o, ext_access_i & (xfer_ack_n_i | bus_switch_ack_n_i), "wait");
    end
    ext_access_i = 1'h0;
    bus_switch_ack_n_i = 1'h0;
    waits = 3'h3;
    tk(1);
    ext_access_i = 1'h1;
    for (int k = 0; k < 4; k++)
    begin
      #1 chk(core_wait_o, k < 3, "wait count");
      tk(1);
    end
    // Bus hold requested during an access, granted once it ends.
    hold_want = 1'h1;
    tk(3);
    chk(bus_hold_ack_n_o, 1'h1, "hold drain");
    chk(core_hold_o, 1'h1, "core hold");
    ext_access_i = 1'h0;
    for (int k = 0; k < 8 && bus_hold_ack_n_o !== 1'h0; k++)
      tk(1);
    chk(bus_hold_ack_n_o, 1'h0, "hold ack");
    chk(instr_ext_oe_o, 1'h0, "released");
    hold_want = 1'h0;
    tk(1);
    chk(bus_hold_ack_n_o, 1'h1, "hold end");
    chk(instr_ext_oe_o, 1'h1, "driven");
    // Instruction extension address, strobe and direction.
    rw = 1'h0;
    for (int i = 0; i < 30; i++)
    begin
      a = 16'($random(seed));
      s = (i == 0) | 1'($random(seed));
      w = 1'($random(seed));
      core_iaddr_i = a;
      core_istrobe_i = s;
      core_iwrite_i = w;
      rw = s ? w : rw;
      tk(1);
      chk(instr_ext_addr_o === a, 1'h1, "ext addr");
      chk(instr_ext_strobe_n_o, !s, "ext strobe");
      chk(prog_rw_ind_o, rw, "rw ind");
    end
    core_istrobe_i = 1'h0;
    // Low power: refused while the core is busy, then granted.
    low_power_req_n_i = 1'h0;
    tk(2);
    chk(low_power_ack_n_o, 1'h1, "lp busy");
    core_lp_idle_i = 1'h1;
    tk(1);
    chk(low_power_ack_n_o, 1'h0, "lp ack");
    chk(core_low_power_o, 1'h1, "lp core");
    low_power_req_n_i = 1'h1;
    tk(1);
    chk(low_power_ack_n_o, 1'h1, "lp end");
    // Instruction cycle flags and snapshot while running.
    {ec, ex, ey} = 3'h0;
    for (int i = 0; i < 40; i++)
    begin
      ic = 1'($random(seed));
      {copro_next_i, xstack_op_i, ystack_op_i, snapshot_out_mode_i} = 4'($random(seed));
      instr_cycle_i = ic;
      {ec, ex, ey} = ic ? {copro_next_i, xstack_op_i, ystack_op_i} : {ec, ex, ey};
      es = snapshot_out_mode_i & ic;
      tk(1);
      chk(copro_valid_n_o, !ec, "copro");
      chk(xstack_flag_o, ex, "xstack");
      chk(ystack_flag_o, ey, "ystack");
      chk(snapshot_out_o, es, "snapshot_out");
    end
    // Halt, single step, resume; no snapshot while halted.
    emu_halt_req_n_i = 1'h0;
    tk(1);
    chk(core_halt_o, 1'h1, "halt");
    chk(idle_flag_o, 1'h1, "idle");
    chk(halt_ack_a_o, 1'h1, "ack");
    emu_halt_req_n_i = 1'h1;
    snapshot_out_mode_i = 1'h1;
    instr_cycle_i = 1'h1;
    emu_step_i = 1'h1;
    tk(1);
    emu_step_i = 1'h0;
    chk(idle_flag_o, 1'h0, "step idle");
    chk(halt_ack_a_o, 1'h1, "step ack");
    chk(snapshot_out_o, 1'h1, "step snapshot_out");
    tk(1);
    instr_cycle_i = 1'h0;
    chk(idle_flag_o, 1'h1, "re-halt");
    chk(snapshot_out_o, 1'h0, "halt snapshot_out");
    emu_resume_i = 1'h1;
    tk(1);
    emu_resume_i = 1'h0;
    chk(core_halt_o, 1'h0, "resume");
    chk(halt_ack_a_o, 1'h0, "resume ack");
    // Breakpoints fire only on the enabled bus.
    for (int b = 0; b < 6; b++)
    begin
      {i_bp_match_i, y_bp_match_i, x_bp_match_i} = 3'h1 << (b % 3);
      {iaddr_bp_en_i, yaddr_bp_en_i, xaddr_bp_en_i} = (b < 3) ? 3'h1 << b : ~(3'h1 << (b % 3));
      tk(1);
      {i_bp_match_i, y_bp_match_i, x_bp_match_i} = 3'h0;
      chk(halt_ack_a_o, b < 3, "bp ack");
      chk(idle_flag_o, b < 3, "bp idle");
      emu_resume_i = 1'h1;
      tk(1);
      emu_resume_i = 1'h0;
    end
    // Test logic reset clears the emulation state only.
    emu_halt_req_n_i = 1'h0;
    tk(1);
    emu_halt_req_n_i = 1'h1;
    trst_n_i = 1'h0;
    tk(1);
    chk(halt_ack_a_o, 1'h0, "trst ack");
    chk(idle_flag_o, 1'h0, "trst idle");
    chk(core_reset_n_o, 1'h1, "trst core");
    tk(1);
    do_reset(1'h1, 3);
    test_done();
  end
endmodule

`default_nettype wire
